// *** include/idm_regs.svh ***
// Purpose: Offsets, field positions, reset values and limits of the internal data memory.
// Assumes: Byte-wide data and an 8-bit internal data address.
// Notes: Definitions only.
`ifndef IDM_REGS_SVH
`define IDM_REGS_SVH
`define IDM_ADDR_W        8
`define IDM_DATA_W        8
`define IDM_LOWER_TOP     8'h7F
`define IDM_PSW_ADDR      8'hD0
`define IDM_PSW_RESET     8'h00
`define IDM_PSW_BANK_LO   3
`define IDM_PSW_BANK_HI   4
`define IDM_SP_ADDR       8'h81
`define IDM_SP_RESET      8'h07
`define IDM_BITRAM_BASE   8'h20
`define IDM_BITRAM_TOP    8'h2F
`define IDM_SFR_BIT_MASK  8'h07
`define IDM_BANK_BYTES    8'h08
`endif

// *** include/idm_pkg.sv ***
// Purpose: Types of the internal data memory block.
// Assumes: Nothing beyond the header constants.
// Notes: Request and answer travel as packed structs.
package idm_pkg;
	typedef enum logic [2:0] {
		IDM_OP_NONE   = 3'h0,
		IDM_OP_DIRECT = 3'h1,
		IDM_OP_INDIR  = 3'h3,
		IDM_OP_REG    = 3'h2,
		IDM_OP_BIT    = 3'h6,
		IDM_OP_PUSH   = 3'h7,
		IDM_OP_POP    = 3'h5,
		IDM_OP_CALL   = 3'h4
	} idm_op_t;

	typedef struct packed {
		idm_op_t     op;
		logic        write;
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic [15:0] ret_addr;
	} idm_req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [7:0]  rdata;
		logic        rbit;
	} idm_rsp_t;
endpackage

// *** src/idm_bitmap.sv ***
// Purpose: Resolve a bit address to a byte address and bit position.
// Assumes: Bit addresses below 80H hit the bit RAM, the rest hit the SPECIAL_FUNCTION_REGISTER_SPACE space.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "idm_regs.svh"
module idm_bitmap (
	input  wire logic [7:0] i_bit_addr,
	output logic      [7:0] o_byte_addr,
	output logic      [2:0] o_bit_pos,
	output logic            o_is_sfr
);
	always_comb begin
		o_is_sfr  = i_bit_addr[7];
		o_bit_pos = i_bit_addr[2:0];
		if (i_bit_addr[7]) begin
			// SPECIAL_FUNCTION_REGISTER_SPACE bit addresses name the byte whose low nibble is 0 or 8.
			o_byte_addr = {i_bit_addr[7:3], 3'h0};
		end else begin
			o_byte_addr = `IDM_BITRAM_BASE + {3'h0, i_bit_addr[7:3]}; // RULE_15 RULE_08
		end
	end
endmodule
`default_nettype wire

// *** src/idm_core.sv ***
// Purpose: Internal data memory: lower RAM, upper RAM, SPECIAL_FUNCTION_REGISTER_SPACE space, banks, bits and stack.
// Assumes: One request per cycle from core logic on the same clock; answer next cycle, or two cycles later for a call.
// Notes: Other SPECIAL_FUNCTION_REGISTER_SPACE bytes are plain storage here; their peripherals live elsewhere.
//
// Contract
// [RULE_01] Internal data addresses are eight bits, a 256-byte space.
// [RULE_02] Direct access above 7FH reaches the SPECIAL_FUNCTION_REGISTER_SPACE space, never upper RAM.
// [RULE_03] Indirect access above 7FH reaches upper RAM, never the SPECIAL_FUNCTION_REGISTER_SPACE space.
// [RULE_04] Upper RAM and SPECIAL_FUNCTION_REGISTER_SPACE space are separate storage sharing addresses 80H-FFH.
// [RULE_05] SFRs at addresses ending 0H or 8H are bit and byte accessible.
// [RULE_06] Lowest 32 RAM bytes are four banks of eight working registers.
// [RULE_07] Status word bits 4 and 3 select the active bank, bit 4 high.
// [RULE_08] RAM bytes 20H-2FH are bit accessible through bit addresses 00H-7FH.
// [RULE_09] Every lower RAM byte is reachable both directly and indirectly.
// [RULE_10] Stack pointer resets to 07H and accepts any software write.
// [RULE_11] Push increments the stack pointer first, then writes the byte.
// [RULE_12] Pop reads the byte first, then decrements the stack pointer.
// [RULE_13] Calls and interrupts save the return address on the stack.
// [RULE_14] Stack accesses use the indirect path over all 256 RAM bytes.
// [RULE_15] Bit address n maps to byte 20H plus n/8, bit n mod 8.
`timescale 1ns/1ps
`default_nettype none
`include "idm_regs.svh"
module idm_core #(
	parameter int ADDR_W = `IDM_ADDR_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire idm_pkg::idm_req_t i_req,
	output logic                  o_busy,
	output idm_pkg::idm_rsp_t     o_rsp,
	output logic            [7:0] o_stack_top_pointer,
	output logic            [7:0] o_program_status_word
);
	localparam int DEPTH = 1 << ADDR_W; // RULE_01

	typedef struct packed {
		logic [DEPTH-1:0][7:0] ram;
		logic [DEPTH-1:0][7:0] special_function_register_space;
		logic                  call_hi;
		logic [7:0]            ret_hi;
		idm_pkg::idm_rsp_t     rsp;
	} idm_state_t;

	idm_state_t state;
	idm_state_t next_state;

	logic [7:0] bit_byte;
	logic [2:0] bit_pos;
	logic       bit_sfr;

	idm_bitmap u_bitmap (
		.i_bit_addr  (i_req.addr),
		.o_byte_addr (bit_byte),
		.o_bit_pos   (bit_pos),
		.o_is_sfr    (bit_sfr)
	);

	// A register number becomes a RAM byte inside the bank chosen by the status word.
	function automatic logic [7:0] bank_addr(input logic [7:0] program_status_word, input logic [2:0] num);
		bank_addr = {3'h0, program_status_word[`IDM_PSW_BANK_HI], program_status_word[`IDM_PSW_BANK_LO], num}; // RULE_06 RULE_07
	endfunction

	function automatic logic sfr_bit_ok(input logic [7:0] a);
		sfr_bit_ok = (a & `IDM_SFR_BIT_MASK) == 8'h00; // RULE_05
	endfunction

	logic [7:0] sp;
	logic [7:0] program_status_word;
	assign sp  = state.special_function_register_space[`IDM_SP_ADDR];
	assign program_status_word = state.special_function_register_space[`IDM_PSW_ADDR];

	always_comb begin
		logic [7:0] byte_v;
		logic [7:0] sp_inc;
		byte_v = 8'h00;
		sp_inc = sp + 8'h01;
		next_state = state;
		next_state.rsp = '0;
		next_state.rsp.valid = i_req.op != idm_pkg::IDM_OP_NONE || state.call_hi;
		if (state.call_hi) begin
			// Second byte of a saved return address; the core is held off this cycle.
			next_state.ram[sp_inc] = state.ret_hi; // RULE_13 RULE_11
			next_state.special_function_register_space[`IDM_SP_ADDR] = sp_inc;
			next_state.call_hi = 1'b0;
			next_state.rsp.valid = 1'b1;
		end else begin
			case (i_req.op)
				idm_pkg::IDM_OP_DIRECT: begin
					if (i_req.addr > `IDM_LOWER_TOP) begin
						// Direct above 7FH: SPECIAL_FUNCTION_REGISTER_SPACE store only.
						next_state.rsp.rdata = state.special_function_register_space[i_req.addr]; // RULE_02 RULE_04
						if (i_req.write) begin
							next_state.special_function_register_space[i_req.addr] = i_req.wdata; // RULE_10
						end
					end else begin
						next_state.rsp.rdata = state.ram[i_req.addr]; // RULE_09
						if (i_req.write) begin
							next_state.ram[i_req.addr] = i_req.wdata;
						end
					end
				end
				idm_pkg::IDM_OP_INDIR: begin
					next_state.rsp.rdata = state.ram[i_req.addr]; // RULE_03 RULE_09 RULE_04
					if (i_req.write) begin
						next_state.ram[i_req.addr] = i_req.wdata;
					end
				end
				idm_pkg::IDM_OP_REG: begin
					next_state.rsp.rdata = state.ram[bank_addr(program_status_word, i_req.addr[2:0])]; // RULE_06
					if (i_req.write) begin
						next_state.ram[bank_addr(program_status_word, i_req.addr[2:0])] = i_req.wdata;
					end
				end
				idm_pkg::IDM_OP_BIT: begin
					if (bit_sfr && !sfr_bit_ok(bit_byte)) begin
						next_state.rsp.err = 1'b1; // RULE_05
					end else if (bit_sfr) begin
						byte_v = state.special_function_register_space[bit_byte];
						next_state.rsp.rbit = byte_v[bit_pos];
						byte_v[bit_pos] = i_req.wdata[0];
						if (i_req.write) begin
							next_state.special_function_register_space[bit_byte] = byte_v; // RULE_05
						end
					end else begin
						byte_v = state.ram[bit_byte];
						next_state.rsp.rbit = byte_v[bit_pos]; // RULE_08 RULE_15
						byte_v[bit_pos] = i_req.wdata[0];
						if (i_req.write) begin
							next_state.ram[bit_byte] = byte_v;
						end
					end
					next_state.rsp.rdata = byte_v;
				end
				idm_pkg::IDM_OP_PUSH: begin
					next_state.special_function_register_space[`IDM_SP_ADDR] = sp_inc;
					next_state.ram[sp_inc] = i_req.wdata; // RULE_11 RULE_14
				end
				idm_pkg::IDM_OP_POP: begin
					next_state.rsp.rdata = state.ram[sp]; // RULE_12 RULE_14
					next_state.special_function_register_space[`IDM_SP_ADDR] = sp - 8'h01;
				end
				idm_pkg::IDM_OP_CALL: begin
					// Low byte first, high byte on the following cycle.
					next_state.special_function_register_space[`IDM_SP_ADDR] = sp_inc;
					next_state.ram[sp_inc] = i_req.ret_addr[7:0]; // RULE_13
					next_state.ret_hi = i_req.ret_addr[15:8];
					next_state.call_hi = 1'b1;
					next_state.rsp.valid = 1'b0;
				end
				default: begin
					next_state.rsp.valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state <= '0;
			state.special_function_register_space[`IDM_SP_ADDR] <= `IDM_SP_RESET; // RULE_10
			state.special_function_register_space[`IDM_PSW_ADDR] <= `IDM_PSW_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign o_busy                = state.call_hi;
	assign o_rsp                 = state.rsp;
	assign o_stack_top_pointer   = sp;
	assign o_program_status_word = program_status_word;

	sp_reset_a: assert property (@(posedge i_clk) !i_reset_n |=> sp == 8'h07) // RULE_10
		else $error("Stack pointer not 07H after reset.");

	sequence push_req_s;
		i_req.op == idm_pkg::IDM_OP_PUSH && !state.call_hi;
	endsequence

	push_order_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_11
		push_req_s |=> sp == $past(sp) + 8'h01 && state.ram[sp] == $past(i_req.wdata))
		else $error("Push did not increment then write.");

	pop_order_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_12
		i_req.op == idm_pkg::IDM_OP_POP && !state.call_hi
		|=> o_rsp.rdata == $past(state.ram[sp]) && sp == $past(sp) - 8'h01)
		else $error("Pop did not read then decrement.");

	direct_sfr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_02
		i_req.op == idm_pkg::IDM_OP_DIRECT && !state.call_hi && i_req.addr[7] && !i_req.write
		|=> o_rsp.rdata == $past(state.special_function_register_space[i_req.addr]))
		else $error("Direct high access missed the SPECIAL_FUNCTION_REGISTER_SPACE space.");

	indirect_ram_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_03
		i_req.op == idm_pkg::IDM_OP_INDIR && !state.call_hi && i_req.write
		|=> state.ram[$past(i_req.addr)] == $past(i_req.wdata)
		&& state.special_function_register_space[$past(i_req.addr)] == $past(state.special_function_register_space[i_req.addr]))
		else $error("Indirect access touched the SPECIAL_FUNCTION_REGISTER_SPACE space.");

	bank_select_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_07
		i_req.op == idm_pkg::IDM_OP_REG && !state.call_hi && !i_req.write
		|=> o_rsp.rdata == $past(state.ram[{3'h0, program_status_word[4:3], i_req.addr[2:0]}]))
		else $error("Working register read from the wrong bank.");

	bit_ram_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_15
		i_req.op == idm_pkg::IDM_OP_BIT && !state.call_hi && !i_req.addr[7]
		|=> o_rsp.rbit == $past(state.ram[8'h20 + {3'h0, i_req.addr[6:3]}][i_req.addr[2:0]]))
		else $error("Bit address mapped to the wrong RAM bit.");

	sfr_bit_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_05
		i_req.op == idm_pkg::IDM_OP_BIT && !state.call_hi && i_req.addr[7]
		|=> o_rsp.err == 1'b0)
		else $error("Bit access to a bit-capable SPECIAL_FUNCTION_REGISTER_SPACE flagged.");

	sequence call_s;
		i_req.op == idm_pkg::IDM_OP_CALL && !state.call_hi;
	endsequence

	call_save_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_13
		call_s |=> o_busy ##1 (!o_busy && o_rsp.valid && sp == $past(sp, 2) + 8'h02))
		else $error("Call did not save two bytes on the stack.");

	// Each request kind except a call answers on the very next edge.
	rsp_valid_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_01
		i_req.op != idm_pkg::IDM_OP_NONE && i_req.op != idm_pkg::IDM_OP_CALL && !state.call_hi
		|=> o_rsp.valid)
		else $error("Request was not answered on the next cycle.");

	reg_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_06
		i_req.op == idm_pkg::IDM_OP_REG && !state.call_hi && i_req.write
		|=> state.ram[$past({3'h0, program_status_word[4:3], i_req.addr[2:0]})] == $past(i_req.wdata))
		else $error("Working register write missed its bank.");

	lower_direct_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_09
		i_req.op == idm_pkg::IDM_OP_DIRECT && !state.call_hi && i_req.write && !i_req.addr[7]
		|=> state.ram[$past(i_req.addr)] == $past(i_req.wdata))
		else $error("Direct write to lower RAM was lost.");

	direct_split_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_04
		i_req.op == idm_pkg::IDM_OP_DIRECT && !state.call_hi && i_req.write && i_req.addr[7]
		|=> state.special_function_register_space[$past(i_req.addr)] == $past(i_req.wdata)
		&& state.ram[$past(i_req.addr)] == $past(state.ram[i_req.addr]))
		else $error("Direct high write touched upper RAM.");

	bit_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_08
		i_req.op == idm_pkg::IDM_OP_BIT && !state.call_hi && i_req.write && !i_req.addr[7]
		|=> state.ram[$past(8'h20 + {4'h0, i_req.addr[6:3]})][$past(i_req.addr[2:0])]
		== $past(i_req.wdata[0]))
		else $error("Bit write landed on the wrong RAM bit.");

	busy_once_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_13
		o_busy |=> !o_busy)
		else $error("Busy stood longer than one cycle.");

	busy_push_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_11
		o_busy |=> sp == $past(sp) + 8'h01)
		else $error("Second return byte did not advance the stack pointer.");
endmodule
`default_nettype wire

// *** testbench/idm_requester.sv ***
// Purpose: Stand-in for the core logic that issues requests to the data memory.
// Assumes: The bench hands over one command and returns it to idle after one edge.
// Notes: Each command goes out one edge after the bench sets it.
`timescale 1ns/1ps
`default_nettype none
module idm_requester (
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_busy,
	input  wire idm_pkg::idm_req_t i_cmd,
	output var  idm_pkg::idm_req_t o_req
);
	// The memory drops requests while busy, so the stand-in sends an idle request instead and that command is lost.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_req <= '0;
		end else begin
			o_req <= i_busy ? '0 : i_cmd;
		end
	end
endmodule
`default_nettype wire

// *** testbench/internal_data_memory_map_tb_top.sv ***
// Purpose: Self-checking bench for the internal data memory.
// Assumes: Answers arrive within a few cycles of each request.
// Notes: Random addresses avoid the stack pointer and status word bytes.
`timescale 1ns/1ps
`default_nettype none
`include "idm_regs.svh"
module internal_data_memory_map_tb_top;
	logic              i_clk;
	logic              i_reset_n;
	logic              busy;
	idm_pkg::idm_req_t cmd;
	idm_pkg::idm_req_t req;
	idm_pkg::idm_rsp_t rsp;
	logic        [7:0] sp;
	logic        [7:0] program_status_word;
	logic        [7:0] got;
	logic              gbit;
	logic              gerr;
	logic        [7:0] a;
	logic        [7:0] v;
	logic        [7:0] w;
	logic       [15:0] ret;
	integer            seed;
	integer            n_fail;
	integer            total_checks;
	integer            i;
	idm_core u_idm_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .o_busy(busy),
		.o_rsp(rsp), .o_stack_top_pointer(sp), .o_program_status_word(program_status_word));
	idm_requester u_idm_requester (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_busy(busy),
		.i_cmd(cmd), .o_req(req));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	function automatic logic [7:0] bank_addr(input logic [1:0] b, input logic [2:0] r);
		return {3'b000, b, r};
	endfunction
	function automatic logic [7:0] bit_byte(input logic [7:0] n);
		return `IDM_BITRAM_BASE + {3'b000, n[7:3]};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic check1(input string what, input logic exp, input logic seen);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic op(input idm_pkg::idm_op_t k, input logic wr, input logic [7:0] ad,
		input logic [7:0] wd);
		integer t;
		@(posedge i_clk);
		cmd <= '{op: k, write: wr, addr: ad, wdata: wd, ret_addr: ret};
		@(posedge i_clk);
		cmd.op <= idm_pkg::IDM_OP_NONE;
		for (t = 0; t < 8; t++) begin
			@(posedge i_clk);
			#1;
			if (rsp.valid === 1'b1) break;
		end
		if (t == 8) begin
			n_fail++;
			tally_and_finish();
		end
		got = rsp.rdata;
		gbit = rsp.rbit;
		gerr = rsp.err;
		check8("latency", (k == idm_pkg::IDM_OP_CALL) ? 8'h01 : 8'h00, 8'(t));
	endtask
	initial begin
		seed = 17;
		n_fail = 0;
		total_checks = 0;
		ret = 16'h0000;
		i_reset_n = 1'b0;
		cmd = '0;
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		#1;
		check8("stack pointer", `IDM_SP_RESET, sp);
		check8("status word", `IDM_PSW_RESET, program_status_word);
		for (i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'h80 : 8'h80 | 8'($random(seed));
			if (a == `IDM_SP_ADDR || a == `IDM_PSW_ADDR) a = 8'hFF;
			v = 8'($random(seed));
			w = ~v;
			op(idm_pkg::IDM_OP_DIRECT, 1'b1, a, v);
			op(idm_pkg::IDM_OP_INDIR, 1'b1, a, w);
			op(idm_pkg::IDM_OP_DIRECT, 1'b0, a, 8'h00);
			check8("direct upper", v, got);
			op(idm_pkg::IDM_OP_INDIR, 1'b0, a, 8'h00);
			check8("indirect upper", w, got);
			a = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
			op(idm_pkg::IDM_OP_DIRECT, 1'b1, a, v);
			op(idm_pkg::IDM_OP_INDIR, 1'b0, a, 8'h00);
			check8("lower indirect", v, got);
		end
		for (i = 0; i < 4; i++) begin
			op(idm_pkg::IDM_OP_DIRECT, 1'b1, `IDM_PSW_ADDR, {3'b000, i[1:0], 3'b000});
			check8("status word", {3'b000, i[1:0], 3'b000}, program_status_word);
			a = 8'($random(seed)) & 8'h07;
			v = 8'($random(seed));
			op(idm_pkg::IDM_OP_REG, 1'b1, a, v);
			op(idm_pkg::IDM_OP_DIRECT, 1'b0, bank_addr(i[1:0], a[2:0]), 8'h00);
			check8("bank register", v, got);
			a = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
			op(idm_pkg::IDM_OP_DIRECT, 1'b1, bit_byte(a), 8'h00);
			op(idm_pkg::IDM_OP_BIT, 1'b1, a, 8'h01);
			check1("old bit", 1'b0, gbit);
			op(idm_pkg::IDM_OP_DIRECT, 1'b0, bit_byte(a), 8'h00);
			check8("bit byte", 8'h01 << a[2:0], got);
		end
		op(idm_pkg::IDM_OP_DIRECT, 1'b1, 8'hE0, 8'h00);
		op(idm_pkg::IDM_OP_BIT, 1'b1, 8'hE3, 8'h01);
		check1("error flag", 1'b0, gerr);
		op(idm_pkg::IDM_OP_DIRECT, 1'b0, 8'hE0, 8'h00);
		check8("register bit", 8'h08, got);
		op(idm_pkg::IDM_OP_DIRECT, 1'b1, `IDM_SP_ADDR, 8'hFE);
		check8("stack pointer", 8'hFE, sp);
		v = 8'($random(seed));
		op(idm_pkg::IDM_OP_PUSH, 1'b1, 8'h00, v);
		check8("stack pointer", 8'hFF, sp);
		op(idm_pkg::IDM_OP_INDIR, 1'b0, 8'hFF, 8'h00);
		check8("pushed byte", v, got);
		op(idm_pkg::IDM_OP_POP, 1'b0, 8'h00, 8'h00);
		check8("popped byte", v, got);
		check8("stack pointer", 8'hFE, sp);
		op(idm_pkg::IDM_OP_DIRECT, 1'b1, `IDM_SP_ADDR, 8'h30);
		ret = 16'($random(seed));
		op(idm_pkg::IDM_OP_CALL, 1'b1, 8'h00, 8'h00);
		check8("stack pointer", 8'h32, sp);
		check1("busy", 1'b0, busy);
		op(idm_pkg::IDM_OP_INDIR, 1'b0, 8'h31, 8'h00);
		check8("return low", ret[7:0], got);
		op(idm_pkg::IDM_OP_INDIR, 1'b0, 8'h32, 8'h00);
		check8("return high", ret[15:8], got);
		tally_and_finish();
	end
endmodule
`default_nettype wire
